// file: cifm_mapper.sv
// Contact input function mapper: per-terminal function codes and decode.
// Assumes contact pins are asynchronous; command outputs feed drive logic.
`timescale 1ns/1ps
module cifm_mapper
  import cifm_pkg::*;
#(
  parameter int RUN_DELAY_CYC = CIFM_RUN_DELAY_CYC,
  parameter int FLASH_CYC = CIFM_FLASH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic init_three_wire,
  input wire logic [6:0] contact_in,
  input wire logic code_wr,
  input wire logic [2:0] code_sel,
  input wire logic [7:0] code_wdata,
  input wire logic power_up_run_accept,
  output logic code_wr_rejected,
  output logic [55:0] code_table,
  output logic run_enable,
  output logic direction_select,
  output logic stop_cmd,
  output logic three_wire_mode,
  output logic [3:0] multi_step_sel,
  output logic jog_select,
  output logic [1:0] accel_sel,
  output logic ramp_hold,
  output logic baseblock,
  output logic fast_stop,
  output logic kinetic_ride_through,
  output logic kinetic_ride_through_2,
  output logic short_circuit_brake,
  output logic fault_reset_pulse,
  output logic external_fault,
  output logic [15:0] external_fault_code,
  output logic [2:0] offset_add,
  output logic dc_injection,
  output logic [1:0] speed_search,
  output logic external_overheat_alarm,
  output logic analog_enable,
  output logic power_up_flash
);
  localparam int CW = 32;

  // Synchronised contacts arrive through the interface
  cifm_sync_if #(.N(CIFM_NUM_IN)) sync_bus ();
  logic [6:0] lvl;

  cifm_sync #(.N(CIFM_NUM_IN)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .raw(contact_in),
    .out(sync_bus)
  );
  assign lvl = sync_bus.level;

  // Code table storage
  logic [7:0] code_q [7];
  logic [7:0] code_d [7];
  logic rej_q; // Write on the last edge refused
  logic rej_d;

  // Membership of the function list
  function automatic logic code_known(input logic [7:0] c);
    logic k;
    k = 1'b0;
    if (c <= CIFM_C_HOLD + 8'h02) k = 1'b1; // 0..C
    if (c == CIFM_C_UNUSED) k = 1'b1;
    if (c >= 8'h10 && c <= 8'h1B) k = 1'b1;
    if (c == 8'h1E) k = 1'b1;
    if (c >= CIFM_C_EF_LO && c <= CIFM_C_EF_HI) k = 1'b1;
    if (c == 8'h30 || c == 8'h31 || c == CIFM_C_MS4) k = 1'b1;
    if (c == 8'h34 || c == 8'h35) k = 1'b1;
    if (c >= CIFM_C_FWD && c <= CIFM_C_OFS3) k = 1'b1;
    if (c >= CIFM_C_DCINJ && c <= CIFM_C_SRCH2) k = 1'b1;
    if (c >= CIFM_C_KEB_NC && c <= 8'h68) k = 1'b1;
    if (c == 8'h6A || c == 8'h75 || c == 8'h76) k = 1'b1;
    if (c >= CIFM_C_KEB2_NC && c <= 8'h7E) k = 1'b1;
    if (c >= 8'h90 && c <= 8'h96) k = 1'b1;
    if (c == CIFM_C_MAX) k = 1'b1;
    return k;
  endfunction

  // Code writes with range and list checks
  always_comb begin
    logic ok;
    ok = 1'b0;
    for (int i = 0; i < CIFM_NUM_IN; i++) code_d[i] = code_q[i];
    rej_d = 1'b0;
    if (code_wr) begin
      ok = code_known(code_wdata) && (code_wdata <= CIFM_C_MAX);
      if (code_sel < 3'd2 && code_wdata < CIFM_C_MIN_S12) ok = 1'b0;
      if (code_sel > 3'd6) ok = 1'b0;
      if (ok) code_d[code_sel] = code_wdata;
      else rej_d = 1'b1;
    end
  end

  // Code registers; defaults loaded in reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      code_q[0] <= CIFM_DEF_IN1;
      code_q[1] <= CIFM_DEF_IN2;
      code_q[2] <= CIFM_DEF_IN3;
      code_q[3] <= CIFM_DEF_IN4;
      code_q[4] <= CIFM_DEF_IN5;
      code_q[5] <= CIFM_DEF_IN6;
      code_q[6] <= CIFM_DEF_IN7;
      rej_q <= 1'b0;
    end else if (init_three_wire) begin
      // Three-wire initialisation reloads all seven terminals, three-wire codes on the last three
      code_q[0] <= CIFM_DEF_IN1;
      code_q[1] <= CIFM_DEF_IN2;
      code_q[2] <= CIFM_DEF_IN3;
      code_q[3] <= CIFM_DEF_IN4;
      code_q[4] <= CIFM_DEF3W_IN5;
      code_q[5] <= CIFM_DEF3W_IN6;
      code_q[6] <= CIFM_DEF3W_IN7;
      rej_q <= 1'b0;
    end else begin
      for (int i = 0; i < CIFM_NUM_IN; i++) code_q[i] <= code_d[i];
      rej_q <= rej_d;
    end
  end

  assign code_wr_rejected = rej_q;
  always_comb begin
    for (int i = 0; i < CIFM_NUM_IN; i++) code_table[i*8 +: 8] = code_q[i];
  end

  // Combinational decode of every terminal
  logic [3:0] ms_c;
  logic jog_c, fwd_c, rev_c, run2_c, dir2_c, tw_c, twdir_c;
  logic [1:0] acc_c;
  logic hold_c, bb_c, fs_c, keb_c, keb2_c, scb_c, frst_c, ef_c, oh_c, aen_c, aen_any_c;
  logic [15:0] efc_c;
  logic [2:0] ofs_c;
  logic dc_c;
  logic [1:0] srch_c;

  always_comb begin
    ms_c = '0;
    jog_c = 1'b0;
    fwd_c = 1'b0;
    rev_c = 1'b0;
    run2_c = 1'b0;
    dir2_c = 1'b0;
    tw_c = 1'b0;
    twdir_c = 1'b0;
    acc_c = '0;
    hold_c = 1'b0;
    bb_c = 1'b0;
    fs_c = 1'b0;
    keb_c = 1'b0;
    keb2_c = 1'b0;
    scb_c = 1'b0;
    frst_c = 1'b0;
    ef_c = 1'b0;
    efc_c = '0;
    oh_c = 1'b0;
    aen_c = 1'b0;
    aen_any_c = 1'b0;
    ofs_c = '0;
    dc_c = 1'b0;
    srch_c = '0;
    for (int i = 0; i < CIFM_NUM_IN; i++) begin
      // Code F and unlisted codes fall through untouched
      unique case (code_q[i])
        CIFM_C_3WIRE: begin
          tw_c = 1'b1;
          twdir_c = twdir_c | lvl[i];
        end
        CIFM_C_MS1: ms_c[0] = ms_c[0] | lvl[i];
        CIFM_C_MS2: ms_c[1] = ms_c[1] | lvl[i];
        CIFM_C_MS3: ms_c[2] = ms_c[2] | lvl[i];
        CIFM_C_MS4: ms_c[3] = ms_c[3] | lvl[i];
        CIFM_C_JOG: jog_c = jog_c | lvl[i];
        CIFM_C_ACC1: acc_c[0] = acc_c[0] | lvl[i];
        CIFM_C_ACC2: acc_c[1] = acc_c[1] | lvl[i];
        CIFM_C_HOLD: hold_c = hold_c | lvl[i];
        CIFM_C_BB_NO: bb_c = bb_c | lvl[i];
        CIFM_C_BB_NC: bb_c = bb_c | ~lvl[i];
        CIFM_C_FS_NO: fs_c = fs_c | lvl[i];
        CIFM_C_FS_NC: fs_c = fs_c | ~lvl[i];
        CIFM_C_KEB_NO: keb_c = keb_c | lvl[i];
        CIFM_C_KEB_NC: keb_c = keb_c | ~lvl[i];
        CIFM_C_KEB2_NO: keb2_c = keb2_c | lvl[i];
        CIFM_C_KEB2_NC: keb2_c = keb2_c | ~lvl[i];
        CIFM_C_SCB_NO: scb_c = scb_c | lvl[i];
        CIFM_C_SCB_NC: scb_c = scb_c | ~lvl[i];
        CIFM_C_FRST: frst_c = frst_c | lvl[i];
        CIFM_C_FWD: fwd_c = fwd_c | lvl[i];
        CIFM_C_REV: rev_c = rev_c | lvl[i];
        CIFM_C_RUN2: run2_c = run2_c | lvl[i];
        CIFM_C_DIR2: dir2_c = dir2_c | lvl[i];
        CIFM_C_OFS1: ofs_c[0] = ofs_c[0] | lvl[i];
        CIFM_C_OFS2: ofs_c[1] = ofs_c[1] | lvl[i];
        CIFM_C_OFS3: ofs_c[2] = ofs_c[2] | lvl[i];
        CIFM_C_DCINJ: dc_c = dc_c | lvl[i];
        CIFM_C_SRCH1: srch_c[0] = srch_c[0] | lvl[i];
        CIFM_C_SRCH2: srch_c[1] = srch_c[1] | lvl[i];
        CIFM_C_OH: oh_c = oh_c | lvl[i];
        CIFM_C_AEN: begin
          aen_any_c = 1'b1;
          aen_c = aen_c | lvl[i];
        end
        default: begin
          // External fault band, low nibble names the variant
          if (code_q[i] >= CIFM_C_EF_LO && code_q[i] <= CIFM_C_EF_HI && lvl[i]) begin
            ef_c = 1'b1;
            efc_c[code_q[i][3:0]] = 1'b1;
          end
        end
      endcase
    end
  end

  // Run request per sequence mode
  logic run_req;
  logic dir_c;
  always_comb begin
    if (tw_c) begin
      run_req = lvl[0] && lvl[1];
      dir_c = twdir_c;
    end else if (run2_c) begin
      run_req = run2_c;
      dir_c = dir2_c;
    end else begin
      run_req = fwd_c ^ rev_c; // Both closed means no run
      dir_c = rev_c && !fwd_c;
    end
  end

  // Run sequencing: power-up gating, start delay, three-wire latch
  logic tw_run_q, tw_run_d; // Latched three-wire run
  logic [1:0] boot_q, boot_d; // Power-up window, outlasts the two sync stages
  logic block_q, block_d; // Run refused until removed
  logic [CW-1:0] dly_q, dly_d; // Start delay counter
  logic run_q, run_d;
  logic [CW-1:0] fl_q, fl_d; // Flash length counter
  logic frst_prev_q, frst_prev_d;
  logic frst_p_q, frst_p_d;

  always_comb begin
    logic req;
    req = 1'b0;
    // Three-wire: momentary run sets, stop contact open clears
    tw_run_d = tw_c && lvl[1] && (tw_run_q || lvl[0]);
    req = tw_c ? tw_run_d : run_req;
    boot_d = (boot_q != 2'h0) ? boot_q - 2'h1 : 2'h0;
    block_d = block_q && req;
    fl_d = (fl_q != '0) ? fl_q - CW'(1) : '0;
    if ((boot_q != 2'h0) && req && !power_up_run_accept) begin
      block_d = 1'b1;
      fl_d = CW'(FLASH_CYC);
    end
    dly_d = '0;
    run_d = 1'b0;
    if (req && !block_d) begin
      if (dly_q >= CW'(RUN_DELAY_CYC - 1)) begin
        run_d = 1'b1;
        dly_d = dly_q;
      end else begin
        dly_d = dly_q + CW'(1);
      end
    end
    // Fault reset acts once on the closing edge
    frst_prev_d = frst_c;
    frst_p_d = frst_c && !frst_prev_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tw_run_q <= 1'b0;
      boot_q <= 2'h3; // Long enough for a held contact to clear the synchroniser
      block_q <= 1'b0;
      dly_q <= '0;
      run_q <= 1'b0;
      fl_q <= '0;
      frst_prev_q <= 1'b0;
      frst_p_q <= 1'b0;
    end else begin
      tw_run_q <= tw_run_d;
      boot_q <= boot_d;
      block_q <= block_d;
      dly_q <= dly_d;
      run_q <= run_d;
      fl_q <= fl_d;
      frst_prev_q <= frst_prev_d;
      frst_p_q <= frst_p_d;
    end
  end

  // Registered command outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      direction_select <= 1'b0;
      stop_cmd <= 1'b0;
      three_wire_mode <= 1'b0;
      multi_step_sel <= '0;
      jog_select <= 1'b0;
      accel_sel <= '0;
      ramp_hold <= 1'b0;
      baseblock <= 1'b0;
      fast_stop <= 1'b0;
      kinetic_ride_through <= 1'b0;
      kinetic_ride_through_2 <= 1'b0;
      short_circuit_brake <= 1'b0;
      external_fault <= 1'b0;
      external_fault_code <= '0;
      offset_add <= '0;
      dc_injection <= 1'b0;
      speed_search <= '0;
      external_overheat_alarm <= 1'b0;
      analog_enable <= 1'b1;
    end else begin
      direction_select <= dir_c;
      stop_cmd <= tw_c && !lvl[1];
      three_wire_mode <= tw_c;
      multi_step_sel <= jog_c ? 4'h0 : ms_c;
      jog_select <= jog_c;
      accel_sel <= acc_c;
      ramp_hold <= hold_c;
      baseblock <= bb_c;
      fast_stop <= fs_c;
      kinetic_ride_through <= keb_c;
      kinetic_ride_through_2 <= keb2_c;
      short_circuit_brake <= scb_c;
      external_fault <= ef_c;
      external_fault_code <= efc_c;
      offset_add <= ofs_c;
      dc_injection <= dc_c;
      speed_search <= srch_c;
      external_overheat_alarm <= oh_c;
      analog_enable <= !aen_any_c || aen_c;
    end
  end

  assign run_enable = run_q;
  assign fault_reset_pulse = frst_p_q;
  assign power_up_flash = fl_q != '0;
endmodule

// file: cifm_pkg.sv
// Package for the contact input function mapper: codes, defaults, timing.
// Assumes a single 100 MHz clock domain shared by all users.
package cifm_pkg;
  localparam int CIFM_NUM_IN = 7; // Contact inputs
  localparam int CIFM_CODE_W = 8; // Function code width
  // Function codes
  localparam logic [7:0] CIFM_C_3WIRE = 8'h00;
  localparam logic [7:0] CIFM_C_MS1 = 8'h03;
  localparam logic [7:0] CIFM_C_MS2 = 8'h04;
  localparam logic [7:0] CIFM_C_MS3 = 8'h05;
  localparam logic [7:0] CIFM_C_JOG = 8'h06;
  localparam logic [7:0] CIFM_C_ACC1 = 8'h07;
  localparam logic [7:0] CIFM_C_BB_NO = 8'h08;
  localparam logic [7:0] CIFM_C_BB_NC = 8'h09;
  localparam logic [7:0] CIFM_C_HOLD = 8'h0A;
  localparam logic [7:0] CIFM_C_OH = 8'h0B;
  localparam logic [7:0] CIFM_C_AEN = 8'h0C;
  localparam logic [7:0] CIFM_C_UNUSED = 8'h0F;
  localparam logic [7:0] CIFM_C_FRST = 8'h14;
  localparam logic [7:0] CIFM_C_FS_NO = 8'h15;
  localparam logic [7:0] CIFM_C_FS_NC = 8'h17;
  localparam logic [7:0] CIFM_C_ACC2 = 8'h1A;
  localparam logic [7:0] CIFM_C_EF_LO = 8'h20;
  localparam logic [7:0] CIFM_C_EF_HI = 8'h2F;
  localparam logic [7:0] CIFM_C_EF_DEF = 8'h24;
  localparam logic [7:0] CIFM_C_MS4 = 8'h32;
  localparam logic [7:0] CIFM_C_FWD = 8'h40;
  localparam logic [7:0] CIFM_C_REV = 8'h41;
  localparam logic [7:0] CIFM_C_RUN2 = 8'h42;
  localparam logic [7:0] CIFM_C_DIR2 = 8'h43;
  localparam logic [7:0] CIFM_C_OFS1 = 8'h44;
  localparam logic [7:0] CIFM_C_OFS2 = 8'h45;
  localparam logic [7:0] CIFM_C_OFS3 = 8'h46;
  localparam logic [7:0] CIFM_C_DCINJ = 8'h60;
  localparam logic [7:0] CIFM_C_SRCH1 = 8'h61;
  localparam logic [7:0] CIFM_C_SRCH2 = 8'h62;
  localparam logic [7:0] CIFM_C_KEB_NC = 8'h65;
  localparam logic [7:0] CIFM_C_KEB_NO = 8'h66;
  localparam logic [7:0] CIFM_C_KEB2_NC = 8'h7A;
  localparam logic [7:0] CIFM_C_KEB2_NO = 8'h7B;
  localparam logic [7:0] CIFM_C_SCB_NO = 8'h7C;
  localparam logic [7:0] CIFM_C_SCB_NC = 8'h7D;
  localparam logic [7:0] CIFM_C_MAX = 8'h9F;
  localparam logic [7:0] CIFM_C_MIN_S12 = 8'h01;
  // Reset defaults, normal and three-wire
  localparam logic [7:0] CIFM_DEF_IN1 = CIFM_C_FWD;
  localparam logic [7:0] CIFM_DEF_IN2 = CIFM_C_REV;
  localparam logic [7:0] CIFM_DEF_IN3 = CIFM_C_EF_DEF;
  localparam logic [7:0] CIFM_DEF_IN4 = CIFM_C_FRST;
  localparam logic [7:0] CIFM_DEF_IN5 = CIFM_C_MS1;
  localparam logic [7:0] CIFM_DEF_IN6 = CIFM_C_MS2;
  localparam logic [7:0] CIFM_DEF_IN7 = CIFM_C_JOG;
  localparam logic [7:0] CIFM_DEF3W_IN5 = CIFM_C_3WIRE;
  localparam logic [7:0] CIFM_DEF3W_IN6 = CIFM_C_MS1;
  localparam logic [7:0] CIFM_DEF3W_IN7 = CIFM_C_MS2;
  // Timing
  localparam int CIFM_CLK_MHZ = 100;
  localparam int CIFM_RUN_DELAY_MS = 50;
  localparam int CIFM_RUN_DELAY_CYC = CIFM_RUN_DELAY_MS * 1000 * CIFM_CLK_MHZ;
  localparam int CIFM_FLASH_MS = 500; // Indicator flash length
  localparam int CIFM_FLASH_CYC = CIFM_FLASH_MS * 1000 * CIFM_CLK_MHZ;
endpackage

// file: cifm_sync_if.sv
// Interface carrying synchronised contact levels between mapper modules.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface cifm_sync_if #(parameter int N = 7);
  logic [N-1:0] level; // Synchronised levels
  modport src (output level);
  modport dst (input level);
endinterface

// file: cifm_sync.sv
// Two-flop synchroniser bank for the contact inputs.
// Assumes raw inputs are asynchronous to clk.
`timescale 1ns/1ps
module cifm_sync #(
  parameter int N = 7
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [N-1:0] raw,
  cifm_sync_if.src out
);
  logic [N-1:0] meta_q; // First stage, read only by second
  logic [N-1:0] meta_d;
  logic [N-1:0] sync_q; // Second stage
  logic [N-1:0] sync_d;

  // Next values
  always_comb begin
    meta_d = raw;
    sync_d = meta_q;
  end

  // Registers, cleared to open contacts
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign out.level = sync_q;
endmodule

// file: cifm_contact_model.sv
// Model of the external contacts wired to the seven mapper terminals.
// Assumes the bench sets the wanted contact state; closed reads high.
`timescale 1ns/1ps
module cifm_contact_model (
  input wire logic [6:0] want,
  output wire logic [6:0] contact_in
);
  // Contacts move 3 ns after the request, which the bench makes 1 ns after a rising
  // edge, so the synchroniser sees changes 4 ns after that edge
  assign #3 contact_in = want;
endmodule

// file: cifm_mapper_chk.sv
// Checker for the contact input function mapper, bound to its ports.
// Assumes one clock domain and synchronous active-low reset.
`timescale 1ns/1ps
module cifm_mapper_chk
  import cifm_pkg::*;
#(
  parameter int RUN_DELAY_CYC = 20,
  parameter int FLASH_CYC = 10
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic init_three_wire,
  input wire logic [6:0] contact_in,
  input wire logic code_wr,
  input wire logic [2:0] code_sel,
  input wire logic [7:0] code_wdata,
  input wire logic code_wr_rejected,
  input wire logic [55:0] code_table,
  input wire logic run_enable,
  input wire logic three_wire_mode,
  input wire logic [3:0] multi_step_sel,
  input wire logic jog_select,
  input wire logic fault_reset_pulse,
  input wire logic analog_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Write that the mapper may take this edge
  wire wr_ok = code_wr && !init_three_wire;
  chk_reset_codes: assert property (
    $rose(rst_b) |-> code_table == 56'h06040314244140) else $error("reset codes wrong");
  chk_reset_outs: assert property (
    $rose(rst_b) |-> analog_enable && !run_enable) else $error("reset outputs wrong");
  chk_low_zero: assert property (
    wr_ok && code_sel < 3'd2 && code_wdata == 8'h00 |=> code_wr_rejected && $stable(code_table))
    else $error("code zero taken on input one or two");
  chk_over_range: assert property (
    wr_ok && code_wdata > 8'h9F |=> code_wr_rejected && $stable(code_table))
    else $error("code above range taken");
  chk_bad_select: assert property (
    wr_ok && code_sel == 3'd7 |=> code_wr_rejected && $stable(code_table))
    else $error("write to missing terminal taken");
  chk_three_init: assert property (
    init_three_wire |=> code_table[55:32] == 24'h040300) else $error("three-wire codes wrong");
  chk_jog_first: assert property (
    jog_select |-> multi_step_sel == 4'h0) else $error("step bits live under jog");
  chk_reset_pulse: assert property (
    fault_reset_pulse |=> !fault_reset_pulse) else $error("fault reset pulse too long");
  // Run must not appear within the first cycles of a fresh request
  chk_run_delay: assert property (
    $rose(contact_in[0]) && !contact_in[1] && !run_enable && !three_wire_mode
    && code_table[15:0] == 16'h4140 |=> !run_enable [*8]) else $error("run started early");
  cover property ($rose(run_enable));
  cover property (code_wr_rejected);
  cover property (fault_reset_pulse);
  cover property (run_enable && three_wire_mode);
endmodule
bind cifm_mapper cifm_mapper_chk #(.RUN_DELAY_CYC(RUN_DELAY_CYC), .FLASH_CYC(FLASH_CYC))
  cifm_mapper_chk_i (.clk(clk), .rst_b(rst_b), .init_three_wire(init_three_wire),
  .contact_in(contact_in), .code_wr(code_wr), .code_sel(code_sel), .code_wdata(code_wdata),
  .code_wr_rejected(code_wr_rejected), .code_table(code_table), .run_enable(run_enable),
  .three_wire_mode(three_wire_mode), .multi_step_sel(multi_step_sel),
  .jog_select(jog_select), .fault_reset_pulse(fault_reset_pulse),
  .analog_enable(analog_enable));

// file: cifm_mapper_test.sv
// Self-checking bench for the contact input function mapper.
// Assumes shortened run and flash counts; contacts come from the model.
`timescale 1ns/1ps
module cifm_mapper_test;
  import cifm_pkg::*;
  localparam int RUN = 20; // Shortened run delay
  localparam logic [55:0] DEF = 56'h06040314244140; // Normal reset codes
  typedef struct packed {logic [7:0] code; logic [21:0] cls; logic [21:0] opn;} cifm_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic init_three_wire = 1'b0;
  logic code_wr = 1'b0;
  logic [2:0] code_sel = 3'h0;
  logic [7:0] code_wdata = 8'h00;
  logic power_up_run_accept = 1'b0;
  logic [6:0] want = 7'h00; // Wanted contact state
  logic [6:0] contact_in;
  logic code_wr_rejected, run_enable, direction_select, stop_cmd, three_wire_mode;
  logic jog_select, ramp_hold, baseblock, fast_stop, kinetic_ride_through;
  logic kinetic_ride_through_2, short_circuit_brake, fault_reset_pulse, external_fault;
  logic dc_injection, external_overheat_alarm, analog_enable, power_up_flash;
  logic [55:0] code_table;
  logic [3:0] multi_step_sel;
  logic [1:0] accel_sel, speed_search;
  logic [2:0] offset_add;
  logic [15:0] external_fault_code;
  logic [55:0] exp_tab; // Shadow of the code table
  logic seen; // Flash observed
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  // Decoded levels gathered into one word for table checks
  wire [21:0] obs = {ramp_hold, baseblock, fast_stop, kinetic_ride_through,
    kinetic_ride_through_2, short_circuit_brake, external_fault, dc_injection,
    external_overheat_alarm, jog_select, analog_enable, accel_sel, offset_add,
    speed_search, multi_step_sel};
  // Code on input three, levels when closed, levels when open
  cifm_row_t rows [28] = '{
    '{8'h03, 22'h000801, 22'h000800}, '{8'h04, 22'h000802, 22'h000800},
    '{8'h05, 22'h000804, 22'h000800}, '{8'h32, 22'h000808, 22'h000800},
    '{8'h06, 22'h001800, 22'h000800}, '{8'h07, 22'h000A00, 22'h000800},
    '{8'h1A, 22'h000C00, 22'h000800}, '{8'h08, 22'h100800, 22'h000800},
    '{8'h09, 22'h000800, 22'h100800}, '{8'h0A, 22'h200800, 22'h000800},
    '{8'h0B, 22'h002800, 22'h000800}, '{8'h0C, 22'h000800, 22'h000000},
    '{8'h0F, 22'h000800, 22'h000800}, '{8'h15, 22'h080800, 22'h000800},
    '{8'h17, 22'h000800, 22'h080800}, '{8'h24, 22'h008800, 22'h000800},
    '{8'h2F, 22'h008800, 22'h000800}, '{8'h44, 22'h000840, 22'h000800},
    '{8'h45, 22'h000880, 22'h000800}, '{8'h46, 22'h000900, 22'h000800},
    '{8'h60, 22'h004800, 22'h000800}, '{8'h61, 22'h000810, 22'h000800},
    '{8'h62, 22'h000820, 22'h000800}, '{8'h65, 22'h000800, 22'h040800},
    '{8'h66, 22'h040800, 22'h000800}, '{8'h7A, 22'h000800, 22'h020800},
    '{8'h7B, 22'h020800, 22'h000800}, '{8'h7C, 22'h010800, 22'h000800}};

  cifm_contact_model cifm_contact_model_i (.want(want), .contact_in(contact_in));
  cifm_mapper #(.RUN_DELAY_CYC(RUN), .FLASH_CYC(10)) cifm_mapper_i (
    .clk(clk), .rst_b(rst_b), .init_three_wire(init_three_wire), .contact_in(contact_in),
    .code_wr(code_wr), .code_sel(code_sel), .code_wdata(code_wdata),
    .power_up_run_accept(power_up_run_accept), .code_wr_rejected(code_wr_rejected),
    .code_table(code_table), .run_enable(run_enable), .direction_select(direction_select),
    .stop_cmd(stop_cmd), .three_wire_mode(three_wire_mode), .multi_step_sel(multi_step_sel),
    .jog_select(jog_select), .accel_sel(accel_sel), .ramp_hold(ramp_hold),
    .baseblock(baseblock), .fast_stop(fast_stop), .kinetic_ride_through(kinetic_ride_through),
    .kinetic_ride_through_2(kinetic_ride_through_2), .short_circuit_brake(short_circuit_brake),
    .fault_reset_pulse(fault_reset_pulse), .external_fault(external_fault),
    .external_fault_code(external_fault_code), .offset_add(offset_add),
    .dc_injection(dc_injection), .speed_search(speed_search),
    .external_overheat_alarm(external_overheat_alarm), .analog_enable(analog_enable),
    .power_up_flash(power_up_flash));

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Step to just after the next rising edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Wait cycles, noting any flash of the indicator
  task automatic wt(input int c);
    repeat (c) begin
      tick();
      seen = seen | (power_up_flash === 1'b1);
    end
  endtask
  // Compare and count; X matches only X
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Hold reset for ten cycles; shadow table returns to defaults
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (10) tick();
    rst_b = 1'b1;
    exp_tab = DEF;
    seen = 1'b0;
  endtask
  // One code write, result checked on the following edge; a spare edge parts writes
  task automatic wr(input logic [2:0] s, input logic [7:0] d, input logic rej);
    code_sel = s;
    code_wdata = d;
    code_wr = 1'b1;
    tick();
    code_wr = 1'b0;
    if (!rej) begin
      exp_tab[s*8+:8] = d;
    end
    chk(64'(code_wr_rejected), 64'(rej));
    chk(64'(code_table), 64'(exp_tab));
    tick();
  endtask
  // Print counts, then the verdict, and stop
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    miscompares++;
    give_verdict();
  end

  // Main sequence
  initial begin
    do_reset();
    // Each code on input three, closed then open
    for (int i = 0; i < 28; i++) begin
      wr(3'd2, rows[i].code, 1'b0);
      want[2] = 1'b1;
      wt(5);
      chk(64'(obs), 64'(rows[i].cls));
      chk(64'(external_fault_code), rows[i].cls[15] ? 64'h1 << rows[i].code[3:0] : 64'h0);
      want[2] = 1'b0;
      wt(5);
      chk(64'(obs), 64'(rows[i].opn));
      $display("row %0d done", i);
    end
    // Refused and boundary writes, a spare edge apart
    wr(3'd0, 8'h00, 1'b1);
    wr(3'd1, 8'h00, 1'b1);
    wr(3'd2, 8'hA0, 1'b1);
    wr(3'd2, 8'h0D, 1'b1);
    wr(3'd7, 8'h03, 1'b1);
    wr(3'd2, 8'h00, 1'b0);
    wr(3'd2, 8'h9F, 1'b0);
    wr(3'd2, 8'h0F, 1'b0);
    $display("write test done");
    // Jog wins over a closed step input
    wr(3'd2, 8'h06, 1'b0);
    want = 7'h14;
    wt(5);
    chk(64'(obs), 64'h1800);
    // Fault reset gives one pulse per closing; jog and step contacts open
    n = 0;
    want = 7'h08;
    repeat (8) begin
      tick();
      n += (fault_reset_pulse === 1'b1);
    end
    chk(64'(n), 64'h1);
    $display("jog and fault reset done");
    // Two-wire forward, both, reverse; fault reset contact opens too
    want = 7'h01;
    wt(10);
    chk(64'(run_enable), 64'h0);
    wt(RUN + 5);
    chk(64'({run_enable, direction_select}), 64'h2);
    want = 7'h03;
    wt(5);
    chk(64'(run_enable), 64'h0);
    want = 7'h02;
    wt(RUN + 8);
    chk(64'({run_enable, direction_select}), 64'h3);
    want = 7'h00;
    wt(5);
    // Alternate two-wire: run plus direction
    wr(3'd0, 8'h42, 1'b0);
    wr(3'd1, 8'h43, 1'b0);
    want = 7'h03;
    wt(RUN + 8);
    chk(64'({run_enable, direction_select}), 64'h3);
    want = 7'h00;
    wt(5);
    chk(64'(run_enable), 64'h0);
    $display("two-wire test done");
    // Mid-run reset restores defaults
    do_reset();
    tick();
    chk(64'(code_table), 64'(DEF));
    chk(64'(obs), 64'h0800);
    // Three-wire load, latch run, direction, stop
    init_three_wire = 1'b1;
    tick();
    init_three_wire = 1'b0;
    chk(64'(code_table[55:32]), 64'h040300);
    want = 7'h03;
    wt(3);
    chk(64'(three_wire_mode), 64'h1);
    want = 7'h12;
    wt(RUN + 8);
    chk(64'({run_enable, direction_select}), 64'h3);
    want = 7'h10;
    wt(5);
    chk(64'(run_enable), 64'h0);
    chk(64'(stop_cmd), 64'h1);
    $display("three-wire test done");
    // Run held through reset: refused, then honoured
    want = 7'h01;
    do_reset();
    wt(RUN + 10);
    chk(64'({run_enable, seen}), 64'h1);
    want = 7'h00;
    wt(5);
    power_up_run_accept = 1'b1;
    want = 7'h01;
    do_reset();
    wt(RUN + 10);
    chk(64'(run_enable), 64'h1);
    want = 7'h00;
    $display("power-up test done");
    give_verdict();
  end
endmodule
